// File: logic/sfc_top.sv
// supply fault, global flag and pwm mapping register bank on classic wishbone
//
// The Wishbone interface to the registers was chosen for this implementation.
`include "sfc_regs.svh"
// Behaviour
// - supply undervoltage switches all output stages off at once and sets status bit D3.
// - supply overvoltage switches all output stages off at once and sets status bit D2.
// - with latch mode 0 the outputs come back by themselves once the supply is valid.
// - with latch mode 1 the outputs stay off until the host clears the undervoltage flag.
// - with latch mode 1 the outputs stay off until the host clears the overvoltage flag.
// - config bit D3 set suppresses the global thermal warning flag.
// - config bit D1 set keeps the global underload flag from ever being set.
// - config bit D0 chooses the pwm input for output two, first input when 1.
// - latch mode lives in control bit D4 and resets to 0, enabling recovery.
// - any per-output underload sets the global underload flag unless masked.
module sfc_top #(
    parameter int N_ULD = `SFC_NUM_ULD
) (
    input  wire logic             clk_i,                       // 40 MHz clock
    input  wire logic             rst_i,                       // sync reset, high
    input  wire logic             wb_cyc_i,                    // bus cycle
    input  wire logic             wb_stb_i,                    // strobe
    input  wire logic             wb_we_i,                     // write enable
    input  wire logic [7:0]       wb_adr_i,                    // byte address
    input  wire logic [3:0]       wb_sel_i,                    // byte lanes
    input  wire logic [31:0]      wb_dat_i,                    // write data
    output logic      [31:0]      wb_dat_o,                    // read data
    output logic                  wb_ack_o,                    // acknowledge
    input  wire logic             supply_undervoltage_i,       // supply below range
    input  wire logic             supply_overvoltage_i,        // supply above range
    input  wire logic             thermal_warning_i,           // raw thermal warning
    input  wire logic [N_ULD-1:0] underload_i,                 // per-output underload
    input  wire logic             first_pwm_input_i,           // pwm input one
    input  wire logic             second_pwm_input_i,          // pwm input two
    output logic                  outputs_enable_o,            // output stages on
    output logic                  first_half_bridge_output_o,  // drive of output one
    output logic                  second_half_bridge_output_o, // drive of output two
    output logic                  global_thermal_warning_o,    // global thermal flag
    output logic                  global_underload_o,          // global underload flag
    output logic                  irq_o                        // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic              uv_reg;
    logic              uv_next;
    logic              ov_reg;
    logic              ov_next;
    logic              tw_mask_reg;
    logic              tw_mask_next;
    logic              uld_mask_reg;
    logic              uld_mask_next;
    logic              swap_reg;
    logic              swap_next;
    logic              latch_reg;
    logic              latch_next;
    logic              gtw_reg;
    logic              gtw_next;
    logic              guld_reg;
    logic              guld_next;
    logic              en_reg;
    logic              en_next;
    logic              p1_reg;
    logic              p1_next;
    logic              p2_reg;
    logic              p2_next;
    sfc_pkg::sfc_evt_t irq_stat_reg;
    sfc_pkg::sfc_evt_t irq_stat_next;
    sfc_pkg::sfc_evt_t irq_en_reg;
    sfc_pkg::sfc_evt_t irq_en_next;
    sfc_pkg::sfc_evt_t ev;
    sfc_pkg::sfc_evt_t clr;
    logic              irq_reg;
    logic              irq_next;
    logic              ack_reg;
    logic              ack_next;
    logic [31:0]       dat_reg;
    logic [31:0]       dat_next;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic              req;
    logic              acc;
    logic              wr_lo;
    logic              rd_st;
    sfc_pkg::sfc_idx_t idx;

    // answer one cycle after the request; effects land on the acked edge
    assign req   = wb_cyc_i & wb_stb_i;
    assign acc   = req & ack_reg;
    assign idx   = wb_adr_i[7:2];
    assign wr_lo = acc & wb_we_i & wb_sel_i[0];
    assign rd_st = acc & ~wb_we_i & (idx == `SFC_IDX_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // flags, configuration and output control

    always_comb begin
        // sticky flags; a live condition outlasts the clearing read
        uv_next = supply_undervoltage_i | (uv_reg & ~rd_st);
        ov_next = supply_overvoltage_i | (ov_reg & ~rd_st);

        tw_mask_next  = tw_mask_reg;
        uld_mask_next = uld_mask_reg;
        swap_next     = swap_reg;
        latch_next    = latch_reg;
        if (wr_lo && idx == `SFC_IDX_CONFIG) begin
            tw_mask_next  = wb_dat_i[`SFC_BIT_TW_MASK];
            uld_mask_next = wb_dat_i[`SFC_BIT_ULD_MASK];
            swap_next     = wb_dat_i[`SFC_BIT_PWM_SWAP];
        end
        if (wr_lo && idx == `SFC_IDX_CONTROL) begin
            latch_next = wb_dat_i[`SFC_BIT_LATCH];
        end

        gtw_next  = thermal_warning_i & ~tw_mask_reg;
        guld_next = (|underload_i) & ~uld_mask_reg;

        // latched mode keeps the stages off while either flag is still set
        en_next = ~(supply_undervoltage_i | supply_overvoltage_i)
                  & ~(latch_reg & (uv_next | ov_next));

        p1_next = first_pwm_input_i & en_next;
        p2_next = (swap_reg ? first_pwm_input_i : second_pwm_input_i) & en_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts

    assign ev[`SFC_EV_UV]  = supply_undervoltage_i & ~uv_reg;
    assign ev[`SFC_EV_OV]  = supply_overvoltage_i & ~ov_reg;
    assign ev[`SFC_EV_TW]  = gtw_next & ~gtw_reg;
    assign ev[`SFC_EV_ULD] = guld_next & ~guld_reg;

    genvar g;
    generate
        for (g = 0; g < `SFC_NUM_EVT; g++) begin : g_irq
            // set wins over a simultaneous clear
            assign clr[g] = wr_lo & (idx == `SFC_IDX_IRQ_CLR) & wb_dat_i[g];
            assign irq_stat_next[g] = ev[g] | (irq_stat_reg[g] & ~clr[g]);
        end
    endgenerate

    always_comb begin
        irq_en_next = irq_en_reg;
        if (wr_lo && idx == `SFC_IDX_IRQ_EN) begin
            irq_en_next = wb_dat_i[`SFC_NUM_EVT-1:0];
        end
        irq_next = |(irq_stat_next & irq_en_next);
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path and acknowledge

    always_comb begin
        ack_next = req & ~ack_reg;
        dat_next = `SFC_RST_DATA;
        // unmapped and write-only addresses read zero
        if (req && !ack_reg) begin
            case (idx)
                `SFC_IDX_STATUS: begin
                    dat_next[`SFC_BIT_UV] = uv_reg;
                    dat_next[`SFC_BIT_OV] = ov_reg;
                end
                `SFC_IDX_CONFIG: begin
                    dat_next[`SFC_BIT_TW_MASK]  = tw_mask_reg;
                    dat_next[`SFC_BIT_ULD_MASK] = uld_mask_reg;
                    dat_next[`SFC_BIT_PWM_SWAP] = swap_reg;
                end
                `SFC_IDX_CONTROL: begin
                    dat_next[`SFC_BIT_LATCH] = latch_reg;
                end
                `SFC_IDX_GFLAGS: begin
                    dat_next[`SFC_BIT_GTW]  = gtw_reg;
                    dat_next[`SFC_BIT_GULD] = guld_reg;
                end
                `SFC_IDX_IRQ_STAT: begin
                    dat_next[`SFC_NUM_EVT-1:0] = irq_stat_reg;
                end
                `SFC_IDX_IRQ_EN: begin
                    dat_next[`SFC_NUM_EVT-1:0] = irq_en_reg;
                end
                default: begin
                    dat_next = `SFC_RST_DATA;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_reg       <= 1'b0;
            ov_reg       <= 1'b0;
            tw_mask_reg  <= 1'b0;
            uld_mask_reg <= 1'b0;
            swap_reg     <= 1'b0;
            latch_reg    <= 1'b0;
            gtw_reg      <= 1'b0;
            guld_reg     <= 1'b0;
            en_reg       <= 1'b0;
            p1_reg       <= 1'b0;
            p2_reg       <= 1'b0;
            irq_stat_reg <= '0;
            irq_en_reg   <= '0;
            irq_reg      <= 1'b0;
            ack_reg      <= 1'b0;
            dat_reg      <= `SFC_RST_DATA;
        end else begin
            uv_reg       <= uv_next;
            ov_reg       <= ov_next;
            tw_mask_reg  <= tw_mask_next;
            uld_mask_reg <= uld_mask_next;
            swap_reg     <= swap_next;
            latch_reg    <= latch_next;
            gtw_reg      <= gtw_next;
            guld_reg     <= guld_next;
            en_reg       <= en_next;
            p1_reg       <= p1_next;
            p2_reg       <= p2_next;
            irq_stat_reg <= irq_stat_next;
            irq_en_reg   <= irq_en_next;
            irq_reg      <= irq_next;
            ack_reg      <= ack_next;
            dat_reg      <= dat_next;
        end
    end

    assign wb_dat_o                    = dat_reg;
    assign wb_ack_o                    = ack_reg;
    assign outputs_enable_o            = en_reg;
    assign first_half_bridge_output_o  = p1_reg;
    assign second_half_bridge_output_o = p2_reg;
    assign global_thermal_warning_o    = gtw_reg;
    assign global_underload_o          = guld_reg;
    assign irq_o                       = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_uv_off;
        @(posedge clk_i) disable iff (rst_i)
        supply_undervoltage_i |=> !outputs_enable_o && uv_reg && !second_half_bridge_output_o;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("undervoltage did not shut down");

    property p_ov_off;
        @(posedge clk_i) disable iff (rst_i)
        supply_overvoltage_i |=> !outputs_enable_o && ov_reg && !first_half_bridge_output_o;
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("overvoltage did not shut down");

    property p_auto_on;
        @(posedge clk_i) disable iff (rst_i)
        !latch_reg && $fell(supply_undervoltage_i | supply_overvoltage_i)
            && !supply_undervoltage_i && !supply_overvoltage_i |=> outputs_enable_o;
    endproperty
    a_auto_on: assert property (p_auto_on) else $error("no automatic recovery");

    property p_uv_latched;
        @(posedge clk_i) disable iff (rst_i)
        latch_reg && uv_reg && !rd_st |=> !outputs_enable_o && uv_reg;
    endproperty
    a_uv_latched: assert property (p_uv_latched) else $error("uv latch released");

    property p_ov_latched;
        @(posedge clk_i) disable iff (rst_i)
        latch_reg && ov_reg && !rd_st |=> !outputs_enable_o && ov_reg;
    endproperty
    a_ov_latched: assert property (p_ov_latched) else $error("ov latch released");

    property p_tw_mask;
        @(posedge clk_i) disable iff (rst_i)
        tw_mask_reg || !thermal_warning_i |=> !global_thermal_warning_o;
    endproperty
    a_tw_mask: assert property (p_tw_mask) else $error("thermal flag not suppressed");

    property p_uld_mask;
        @(posedge clk_i) disable iff (rst_i)
        uld_mask_reg [*2] |-> !global_underload_o;
    endproperty
    a_uld_mask: assert property (p_uld_mask) else $error("masked underload flag set");

    property p_swap;
        @(posedge clk_i) disable iff (rst_i)
        swap_reg |=> second_half_bridge_output_o
            == ($past(first_pwm_input_i) & outputs_enable_o);
    endproperty
    a_swap: assert property (p_swap) else $error("output two pwm mapping wrong");

    property p_latch_rst;
        @(posedge clk_i)
        rst_i |=> !latch_reg && !uv_reg && !ov_reg && !swap_reg && !tw_mask_reg;
    endproperty
    a_latch_rst: assert property (p_latch_rst) else $error("reset value not zero");

    property p_uld_set;
        @(posedge clk_i) disable iff (rst_i)
        (|underload_i) && !uld_mask_reg |=> global_underload_o;
    endproperty
    a_uld_set: assert property (p_uld_set) else $error("global underload not set");

    property p_reserved;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:5] == 27'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("unused bits not zero");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        supply_undervoltage_i && !uv_reg && irq_en_reg[`SFC_EV_UV]
            && !(wr_lo && idx == `SFC_IDX_IRQ_EN) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("undervoltage interrupt missing");

endmodule

// File: logic/sfc_regs.svh
// register map, field positions and reset values of the supply fault register bank
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

// register indices; byte address is four times the index
`define SFC_IDX_STATUS   6'h12
`define SFC_IDX_CONFIG   6'h3f
`define SFC_IDX_CONTROL  6'h13
`define SFC_IDX_GFLAGS   6'h14
`define SFC_IDX_IRQ_STAT 6'h20
`define SFC_IDX_IRQ_CLR  6'h21
`define SFC_IDX_IRQ_EN   6'h22

// supply fault status fields
`define SFC_BIT_UV 3
`define SFC_BIT_OV 2
// configuration fields
`define SFC_BIT_TW_MASK  3
`define SFC_BIT_ULD_MASK 1
`define SFC_BIT_PWM_SWAP 0
// control field
`define SFC_BIT_LATCH 4
// global flag readback fields
`define SFC_BIT_GTW  0
`define SFC_BIT_GULD 1

// interrupt event positions
`define SFC_EV_UV  0
`define SFC_EV_OV  1
`define SFC_EV_TW  2
`define SFC_EV_ULD 3
`define SFC_NUM_EVT 4

`define SFC_RST_WORD 16'h0000
`define SFC_RST_DATA 32'h0000_0000
`define SFC_NUM_ULD  4

`endif

// File: logic/sfc_pkg.sv
// shared types of the supply fault register bank
package sfc_pkg;
`include "sfc_regs.svh"
    typedef logic [15:0]              sfc_word_t;
    typedef logic [`SFC_NUM_EVT-1:0]  sfc_evt_t;
    typedef logic [5:0]               sfc_idx_t;
endpackage

// File: sim/sfc_host.sv
// wishbone classic master model standing in for the host microcontroller
module sfc_host (
    input  wire logic        clk_i, // bus clock
    input  wire logic        ack_i, // slave acknowledge
    output logic             cyc_o, // bus cycle
    output logic             stb_o, // strobe
    output logic             we_o,  // write enable
    output logic [7:0]       adr_o, // byte address
    output logic [3:0]       sel_o, // byte lanes
    output logic [31:0]      dat_o  // write data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cyc_o = 1'h0;
        stb_o = 1'h0;
        we_o  = 1'h0;
        adr_o = 8'h00;
        sel_o = 4'hf;
        dat_o = 32'hffff_ffff;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one single cycle; call right after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_o <= 1'h1;
        stb_o <= 1'h1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= d;
        // no assumed latency; only the bench timeout ends a hung wait
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'h1);
        cyc_o <= 1'h0;
        stb_o <= 1'h0;
        we_o  <= 1'h0;
        // released data inverted so a stale word never looks valid
        dat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule

// File: sim/sfc_top_test.sv
// self-checking bench of the supply fault register bank
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module sfc_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_i, rst_i, cyc, stb, we, ack, uv, ov, tw, pa, pb;
    logic        en, o1, o2, gtw, guld, irq;
    logic [7:0]  adr;
    logic [3:0]  sel, uld;
    logic [31:0] wdat, rdat, r;
    logic [1:0]  p;
    logic [31:0] exp_q[$];
    int          bad_count, compares, cycles;

    initial clk_i = 1'h0;
    always #12.5 clk_i = ~clk_i;

    sfc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .supply_undervoltage_i(uv), .supply_overvoltage_i(ov),
        .thermal_warning_i(tw), .underload_i(uld), .first_pwm_input_i(pa),
        .second_pwm_input_i(pb), .outputs_enable_o(en), .first_half_bridge_output_o(o1),
        .second_half_bridge_output_o(o2), .global_thermal_warning_o(gtw),
        .global_underload_o(guld), .irq_o(irq));

    sfc_host host_u (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host_u.xfer(1'h0, a, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'h1, a, d);
    endtask

    task automatic nxt(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // read data stands only in the ack cycle
    always @(posedge clk_i) begin
        if (ack === 1'h1 && we === 1'h0)
            `CHK(rdat, exp_q.pop_front())
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_i, uv, ov, tw, pa, pb, uld} = {1'h1, 9'h000};
        void'($urandom(50));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        rd(8'h48, 32'h0);
        rd(8'hfc, 32'h0);
        rd(8'h4c, 32'h0);
        rd(8'h00, 32'h0);
        r = $urandom;
        wr(8'hfc, r);
        rd(8'hfc, r & 32'h0000_000b);
        $display("test reset and access done");
        for (int s = 0; s < 2; s++) begin
            wr(8'hfc, 32'(s));
            for (int k = 0; k < 8; k++) begin
                p = 2'($urandom);
                pa <= p[0];
                pb <= p[1];
                nxt(1);
                `CHK(o2, (s == 1) ? p[0] : p[1])
                `CHK(o1, p[0])
                @(posedge clk_i);
            end
        end
        $display("test pwm mapping done");
        tw  <= 1'h1;
        uld <= 4'($urandom_range(15, 1));
        for (int m = 0; m < 2; m++) begin
            wr(8'hfc, (m == 1) ? 32'h0000_000a : 32'h0);
            nxt(1);
            `CHK(gtw, m == 0)
            `CHK(guld, m == 0)
            @(posedge clk_i);
            rd(8'h50, (m == 1) ? 32'h0 : 32'h3);
        end
        {tw, uld} <= 5'h00;
        wr(8'hfc, 32'h0);
        $display("test global flag masks done");
        pa <= 1'h1;
        for (int md = 0; md < 2; md++) begin
            for (int f = 0; f < 2; f++) begin
                wr(8'h4c, (md == 1) ? 32'h0000_0010 : 32'h0);
                if (f == 1)
                    ov <= 1'h1;
                else
                    uv <= 1'h1;
                nxt(1);
                `CHK(en, 1'h0)
                @(posedge clk_i);
                {uv, ov} <= 2'h0;
                nxt(3);
                `CHK(en, md == 0)
                `CHK(o1, md == 0)
                @(posedge clk_i);
                rd(8'h48, (f == 1) ? 32'h4 : 32'h8);
                nxt(1);
                `CHK(en, 1'h1)
                @(posedge clk_i);
                rd(8'h48, 32'h0);
            end
        end
        $display("test supply faults done");
        wr(8'h4c, 32'h0);
        wr(8'h84, 32'h0000_000f);
        wr(8'h88, 32'h0000_0002);
        ov <= 1'h1;
        @(posedge clk_i);
        ov <= 1'h0;
        nxt(2);
        `CHK(irq, 1'h1)
        @(posedge clk_i);
        wr(8'h88, 32'h0);
        nxt(1);
        `CHK(irq, 1'h0)
        @(posedge clk_i);
        rd(8'h80, 32'h2);
        rd(8'h84, 32'h0);
        wr(8'h84, 32'h0000_0002);
        rd(8'h80, 32'h0);
        $display("test interrupt done");
        test_done();
    end
endmodule
